// file: doc_pkg.sv
package doc_pkg;
   // ---------------------------------------------
   // register map
   // ---------------------------------------------
   localparam int DOC_NREG = 6;
   localparam int DOC_NCFG = 5;
   localparam logic [2:0] DOC_IDX_OUTPUT_CH9_POLARITY_SHUTDOWN = 3'h0;
   localparam logic [2:0] DOC_IDX_OUTPUT_CH9_FUNCTION_GROUP = 3'h1;
   localparam logic [2:0] DOC_IDX_OUTPUT_CH10_POLARITY_SHUTDOWN = 3'h2;
   localparam logic [2:0] DOC_IDX_OUTPUT_CH10_FUNCTION_GROUP = 3'h3;
   localparam logic [2:0] DOC_IDX_CMD = 3'h4;
   localparam logic [2:0] DOC_IDX_STATUS = 3'h5;
   localparam int DOC_IDX_LSB = 2;
   localparam int DOC_IDX_W = 3;
   localparam int DOC_REG_W = 16;
   localparam logic [15:0] DOC_REG_RST = 16'h0000;
   localparam logic [1:0] DOC_RESP_OKAY = 2'h0;
   localparam logic [1:0] DOC_RESP_SLVERR = 2'h2;
   // ---------------------------------------------
   // digit fields
   // ---------------------------------------------
   localparam int DOC_DIGIT_W = 4;
   localparam int DOC_POL_LSB = 0;
   localparam int DOC_HOLD_LSB = 4;
   localparam int DOC_FUNC_LSB = 0;
   localparam int DOC_GRP_LSB = 4;
   localparam int DOC_GRP_W = 3;
   localparam int DOC_NGRP = 8;
   localparam int DOC_NCH = 2;
   localparam logic [3:0] DOC_POL_NEG = 4'h1;
   localparam logic [3:0] DOC_SHUT_HOLD = 4'h1;
   localparam logic [3:0] DOC_FUNC_DIGITAL = 4'h0;
   localparam logic [3:0] DOC_FUNC_LEVEL = 4'h2;
   localparam logic DOC_PIN_INIT = 1'b0;
   localparam logic DOC_PIN_OFF = 1'b0;
endpackage

// file: doc_channel.sv
`timescale 1ns/1ps
module doc_channel (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // settings
   input wire logic [doc_pkg::DOC_REG_W-1:0] setting_one,
   input wire logic [doc_pkg::DOC_REG_W-1:0] setting_two,
   // sources
   input wire logic cmd_value,
   input wire logic [doc_pkg::DOC_NGRP-1:0] level_match,
   input wire logic comm_shutoff,
   // pin
   output logic pin_q
);
   import doc_pkg::*;

   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   // only the two low digits are looked at
   wire [3:0] pol_code = setting_one[DOC_POL_LSB +: DOC_DIGIT_W];
   wire [3:0] shut_code = setting_one[DOC_HOLD_LSB +: DOC_DIGIT_W];
   wire [3:0] func_code = setting_two[DOC_FUNC_LSB +: DOC_DIGIT_W];
   wire [2:0] grp_code = setting_two[DOC_GRP_LSB +: DOC_GRP_W];
   wire invert = (pol_code == DOC_POL_NEG);
   wire hold = (shut_code == DOC_SHUT_HOLD);
   wire is_dig = (func_code == DOC_FUNC_DIGITAL);
   wire is_lvl = (func_code == DOC_FUNC_LEVEL);
   wire lvl_sel = level_match[grp_code];
   wire src = is_dig ? cmd_value : lvl_sel;
   wire live = (is_dig | is_lvl) ? (src ^ invert) : DOC_PIN_OFF;
   wire hold_val = hold ? pin_q : DOC_PIN_INIT;
   logic pin_d;
   assign pin_d = comm_shutoff ? hold_val : live;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_q <= DOC_PIN_INIT;
      end else if (ce) begin
         pin_q <= pin_d;
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   property p_polarity;
      @(posedge aclk) disable iff (!aresetn)
      (ce && !comm_shutoff && is_dig) |=> (pin_q == ($past(cmd_value) ^ $past(invert)));
   endproperty
   a_polarity: assert property (p_polarity) else $error("polarity not applied");

   property p_clear;
      @(posedge aclk) disable iff (!aresetn)
      (ce && comm_shutoff && !hold) |=> (pin_q == DOC_PIN_INIT);
   endproperty
   a_clear: assert property (p_clear) else $error("clear on shutoff failed");

   property p_hold;
      @(posedge aclk) disable iff (!aresetn)
      (comm_shutoff && hold) [*2] |-> $stable(pin_q);
   endproperty
   a_hold: assert property (p_hold) else $error("hold on shutoff failed");

   property p_level;
      @(posedge aclk) disable iff (!aresetn)
      (ce && !comm_shutoff && is_lvl) |=>
         (pin_q == ($past(level_match[grp_code]) ^ $past(invert)));
   endproperty
   a_level: assert property (p_level) else $error("level source not driven");

   property p_off;
      @(posedge aclk) disable iff (!aresetn)
      (ce && !comm_shutoff && !is_dig && !is_lvl) |=> (pin_q == DOC_PIN_OFF);
   endproperty
   a_off: assert property (p_off) else $error("undefined function not off");

   property p_group_last;
      @(posedge aclk) disable iff (!aresetn)
      (ce && !comm_shutoff && is_lvl && !invert && grp_code == 3'h7) |=>
         (pin_q == $past(level_match[DOC_NGRP-1]));
   endproperty
   a_group_last: assert property (p_group_last) else $error("group 8 not selected");
endmodule

// file: doc_top.sv
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module doc_top #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // system side
   input wire logic comm_shutoff,
   input wire logic [doc_pkg::DOC_NGRP-1:0] level_match,
   // pins
   output logic output_channel_nine,
   output logic output_channel_ten
);
   import doc_pkg::*;

   // ---------------------------------------------
   // address decode
   // ---------------------------------------------
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      logic [DOC_IDX_W-1:0] idx;
      idx = a[DOC_IDX_LSB +: DOC_IDX_W];
      addr_ok = (a >> (DOC_IDX_LSB + DOC_IDX_W)) == '0 && idx < DOC_IDX_W'(DOC_NREG);
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [DOC_REG_W-1:0] cfg_q [DOC_NCFG];
   logic [DOC_NCH-1:0] pins;

   wire aw_take = awvalid & wvalid & ~awready_q & ~bvalid_q;
   wire wr_fire = awready_q & awvalid & wvalid;
   wire [DOC_IDX_W-1:0] wr_idx = awaddr[DOC_IDX_LSB +: DOC_IDX_W];
   wire wr_ok = addr_ok(awaddr);
   wire ar_take = arvalid & ~arready_q & ~rvalid_q;
   wire rd_fire = arready_q & arvalid;
   wire [DOC_IDX_W-1:0] rd_idx = araddr[DOC_IDX_LSB +: DOC_IDX_W];
   wire rd_ok = addr_ok(araddr);
   wire [DOC_REG_W-1:0] status_w = {{(DOC_REG_W-DOC_NCH-1){1'b0}}, comm_shutoff, pins};
   wire [DOC_REG_W-1:0] rd_word = !rd_ok ? DOC_REG_RST :
                                  ((rd_idx == DOC_IDX_STATUS) ? status_w : cfg_q[rd_idx]);

   // ---------------------------------------------
   // write channel
   // ---------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= DOC_RESP_OKAY;
      end else if (ce) begin
         awready_q <= aw_take;
         wready_q <= aw_take;
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? DOC_RESP_OKAY : DOC_RESP_SLVERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < DOC_NCFG; i++) begin
            cfg_q[i] <= DOC_REG_RST;
         end
      end else if (ce && wr_fire && wr_ok && wr_idx < DOC_IDX_W'(DOC_NCFG)) begin
         cfg_q[wr_idx] <= merge(cfg_q[wr_idx], wdata, wstrb);
      end
   end

   // ---------------------------------------------
   // read channel
   // ---------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= DOC_RESP_OKAY;
      end else if (ce) begin
         arready_q <= ar_take;
         if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_word};
            rresp_q <= rd_ok ? DOC_RESP_OKAY : DOC_RESP_SLVERR;
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   // ---------------------------------------------
   // output channels
   // ---------------------------------------------
   for (genvar c = 0; c < DOC_NCH; c++) begin : g_ch
      doc_channel u_ch (
         .aclk(aclk),
         .aresetn(aresetn),
         .ce(ce),
         .setting_one(cfg_q[2*c]),
         .setting_two(cfg_q[2*c+1]),
         .cmd_value(cfg_q[DOC_IDX_CMD][c]),
         .level_match(level_match),
         .comm_shutoff(comm_shutoff),
         .pin_q(pins[c])
      );
   end

   assign output_channel_nine = pins[0];
   assign output_channel_ten = pins[1];

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   property p_bvalid_stays;
      @(posedge aclk) disable iff (!aresetn)
      (bvalid_q && !bready) |=> bvalid_q;
   endproperty
   a_bvalid_stays: assert property (p_bvalid_stays) else $error("bvalid dropped early");

   property p_write_lands;
      @(posedge aclk) disable iff (!aresetn)
      (ce && wr_fire && awaddr == '0 && wstrb[1:0] == 2'h3) |=> (cfg_q[0] == $past(wdata[15:0]));
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("write did not land");

   property p_ready_pair;
      @(posedge aclk) disable iff (!aresetn)
      awready_q == wready_q;
   endproperty
   a_ready_pair: assert property (p_ready_pair) else $error("write readies apart");

   property p_aw_pulse;
      @(posedge aclk) disable iff (!aresetn)
      (ce && awready_q) |=> !awready_q;
   endproperty
   a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than a cycle");

   property p_ar_pulse;
      @(posedge aclk) disable iff (!aresetn)
      (ce && arready_q) |=> !arready_q;
   endproperty
   a_ar_pulse: assert property (p_ar_pulse) else $error("arready longer than a cycle");

   property p_bresp_stays;
      @(posedge aclk) disable iff (!aresetn)
      (bvalid_q && !bready) |=> $stable(bresp_q);
   endproperty
   a_bresp_stays: assert property (p_bresp_stays) else $error("bresp changed early");

   property p_rvalid_stays;
      @(posedge aclk) disable iff (!aresetn)
      (rvalid_q && !rready) |=> (rvalid_q && $stable(rdata_q) && $stable(rresp_q));
   endproperty
   a_rvalid_stays: assert property (p_rvalid_stays) else $error("read answer dropped early");

   property p_read_unmapped;
      @(posedge aclk) disable iff (!aresetn)
      (ce && rd_fire && !rd_ok) |=> (rdata_q == 32'h0000_0000 && rresp_q == DOC_RESP_SLVERR);
   endproperty
   a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read answered");

   property p_write_unmapped;
      @(posedge aclk) disable iff (!aresetn)
      (ce && wr_fire && !wr_ok) |=> (bresp_q == DOC_RESP_SLVERR);
   endproperty
   a_write_unmapped: assert property (p_write_unmapped) else $error("unmapped write okay");

   property p_status_read;
      @(posedge aclk) disable iff (!aresetn)
      (ce && rd_fire && rd_ok && rd_idx == DOC_IDX_STATUS) |=>
         (rdata_q[DOC_NCH-1:0] == $past(pins) && rdata_q[DOC_NCH] == $past(comm_shutoff));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status word wrong");

   property p_freeze;
      @(posedge aclk) disable iff (!aresetn)
      !ce |=> ($stable(pins) && $stable(bvalid_q) && $stable(rvalid_q));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");

   c_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire);
   c_read: cover property (@(posedge aclk) disable iff (!aresetn) rd_fire);
   c_shutoff: cover property (@(posedge aclk) disable iff (!aresetn)
      comm_shutoff && pins != '0);
   c_stall: cover property (@(posedge aclk) disable iff (!aresetn) bvalid_q && !bready);
   c_freeze: cover property (@(posedge aclk) disable iff (!aresetn) !ce && pins != '0);
endmodule

// file: doc_load.sv
`timescale 1ns/1ps
module doc_load (
   // clock
   input wire logic aclk,
   // pins from the block
   input wire logic pin_nine,
   input wire logic pin_ten,
   // levels seen by the load
   output logic [1:0] seen_q
);
   always_ff @(posedge aclk) begin
      seen_q <= {pin_ten, pin_nine};
   end
endmodule

// file: tb_digital_output_channel_config.sv
`timescale 1ns/1ps
module tb_digital_output_channel_config;
   import doc_pkg::*;
   logic aclk, aresetn, ce, shut;
   logic [7:0] awaddr, araddr, lm;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, p9, p10;
   logic [31:0] wdata, rdata, got;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, seen, rsp;
   logic [15:0] m [5];
   logic [1:0] e2;
   int n_fail = 0, check_count = 0, cyc = 0, i, stall = 0;
   // ---------------------------------------------
   // design and load
   // ---------------------------------------------
   doc_top #(.ADDR_W(8)) doc_top_inst (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .comm_shutoff(shut), .level_match(lm),
      .output_channel_nine(p9), .output_channel_ten(p10));
   doc_load doc_load_inst (.aclk, .pin_nine(p9), .pin_ten(p10), .seen_q(seen));
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task results;
      $display("fails %0d checks %0d", n_fail, check_count);
      if (n_fail == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e, input string s);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, s, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      awaddr <= a;
      wdata <= {16'h0, d};
      wstrb <= 4'h3;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= (stall == 0);
      do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      repeat (stall) @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      rsp = bresp;
      if (a < 8'h14) m[a[4:2]] = d;
   endtask
   task rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (stall == 0);
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      repeat (stall) @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      got = rdata;
      rsp = rresp;
   endtask
   function automatic logic ex(input logic [15:0] s1, input logic [15:0] s2, input logic c);
      logic v;
      v = (s2[3:0] == 4'h0) ? c : lm[s2[6:4]];
      if (s2[3:0] != 4'h0 && s2[3:0] != 4'h2) return 1'b0;
      return v ^ (s1[3:0] == 4'h1);
   endfunction
   task pins;
      repeat (3) @(posedge aclk);
      chk({30'h0, seen}, {30'h0, ex(m[2], m[3], m[4][1]), ex(m[0], m[1], m[4][0])}, "pins");
   endtask
   task rdall;
      for (int k = 0; k < 5; k++) begin
         rd(8'(k * 4));
         chk(got, {16'h0, m[k]}, "reg");
      end
      rd(8'h14);
      chk(got, {29'h0, shut, ex(m[2], m[3], m[4][1]), ex(m[0], m[1], m[4][0])}, "status");
   endtask
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      aresetn = 1'b0;
      ce = 1'b1;
      {awaddr, araddr, wdata, wstrb, shut, lm} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      foreach (m[k]) m[k] = DOC_REG_RST;
      void'($urandom(32'h456d));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdall();
      rd(8'h18);
      chk({30'h0, rsp}, {30'h0, DOC_RESP_SLVERR}, "unmapped read");
      chk(got, 32'h0, "unmapped data");
      wr(8'h1c, 16'hffff);
      chk({30'h0, rsp}, {30'h0, DOC_RESP_SLVERR}, "unmapped write");
      for (i = 0; i < 32; i++) begin
         lm <= 8'($urandom);
         wr(8'h00, {15'h0, i[4]});
         wr(8'h04, {9'h0, 3'($urandom), i[3:0]});
         wr(8'h08, {15'h0, ~i[4]});
         wr(8'h0c, {9'h0, 3'($urandom), 4'(15 - i)});
         wr(8'h10, 16'($urandom % 4));
         pins();
      end
      for (i = 0; i < 8; i++) begin
         lm <= 8'($urandom);
         wr(8'h04, {9'h0, i[2:0], 4'h2});
         wr(8'h0c, {9'h0, 3'(7 - i), 4'h2});
         pins();
      end
      e2 = {ex(m[2], m[3], m[4][1]), ex(m[0], m[1], m[4][0])};
      ce <= 1'b0;
      lm <= ~lm;
      repeat (3) @(posedge aclk);
      chk({30'h0, seen}, {30'h0, e2}, "frozen");
      ce <= 1'b1;
      pins();
      stall = 3;
      wr(8'h10, 16'h5a5a);
      rd(8'h10);
      stall = 0;
      chk(got, {16'h0, m[4]}, "stalled read");
      rdall();
      for (i = 0; i < 2; i++) begin
         wr(8'h00, {11'h0, i[0], 4'h0});
         wr(8'h04, 16'h0);
         wr(8'h10, 16'h1);
         pins();
         shut <= 1'b1;
         wr(8'h10, 16'h0);
         repeat (3) @(posedge aclk);
         chk({31'h0, seen[0]}, {31'h0, i[0]}, "shutoff");
         rd(8'h14);
         chk(got & 32'h5, {29'h0, 1'b1, 1'b0, i[0]}, "status shutoff");
         shut <= 1'b0;
         pins();
      end
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (m[k]) m[k] = DOC_REG_RST;
      @(posedge aclk);
      rdall();
      results();
   end
endmodule
